// file: pin_override_pkg.sv
// constants for the port d / port e alternate function override block
package pin_override_pkg;
   localparam int unsigned CLK_PERIOD_NS    = 10;
   localparam int unsigned SPIKE_WIDTH_NS   = 50;
   // spike shorter than this is dropped; a pulse must persist this many cycles
   localparam int unsigned SPIKE_CYCLES     = (SPIKE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SPIKE_CNT_W      = 3;
   localparam int unsigned PORT_W           = 8;
   // port d bit positions
   localparam int unsigned PD_SCL           = 0;
   localparam int unsigned PD_SDA           = 1;
   localparam int unsigned PD_RX1           = 2;
   localparam int unsigned PD_TX1           = 3;
   localparam int unsigned PD_CAP1          = 4;
   localparam int unsigned PD_SERIAL1_EXT_CLOCK          = 5;
   localparam int unsigned PD_T1            = 6;
   localparam int unsigned PD_T0            = 7;
   // port e bit positions
   localparam int unsigned PE_SERIAL0_EXT_CLOCK          = 2;
   localparam int unsigned PE_TIMER3_COMPARE_A_OUT          = 3;
   localparam int unsigned PE_TIMER3_COMPARE_B_OUT          = 4;
   localparam int unsigned PE_TIMER3_COMPARE_C_OUT          = 5;
   localparam int unsigned PE_T3            = 6;
   localparam int unsigned PE_DIVIDED_CLOCK_PIN          = 7;
   localparam logic [SPIKE_CNT_W-1:0] SPIKE_CNT_RESET = 3'h0;
   localparam logic [SPIKE_CNT_W-1:0] SPIKE_LIMIT =
      SPIKE_CNT_W'(SPIKE_CYCLES);
   localparam logic [7:0] PORT_RESET        = 8'h00;
endpackage

// file: spike_filter.sv
// glitch filter: output follows input only after it holds steady long enough
`timescale 1ns/1ps
module spike_filter
   import pin_override_pkg::*;
(
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // filter path
   input  wire logic raw_in,
   output logic      filt_out
);
   logic [SPIKE_CNT_W-1:0] cnt;
   logic [SPIKE_CNT_W-1:0] next_cnt;
   logic                   next_filt_out;

   // count cycles the input differs from the output
   always_comb begin
      next_cnt      = SPIKE_CNT_RESET;
      next_filt_out = filt_out;
      if (raw_in != filt_out) begin
         if (cnt + 3'h1 >= SPIKE_LIMIT) begin
            next_filt_out = raw_in;
         end else begin
            next_cnt = cnt + 3'h1;
         end
      end
   end

   // state registers; idle level of the bus is high
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cnt      <= SPIKE_CNT_RESET;
         filt_out <= 1'b1;
      end else begin
         cnt      <= next_cnt;
         filt_out <= next_filt_out;
      end
   end
endmodule

// file: port_d_e_alt_function_override.sv
// alternate function override for port d bits 7:0 and port e bits 7:2
// Operation
// - two-wire enable hands port d bit 0 to the two-wire clock line
// - two-wire clock input filtered of spikes under 50 ns, driven open-drain
// - two-wire enable turns on slew control on bits 0, 1; filtered inputs
// - port d bits 2..0 pull-up override equals port bit and pull-up term
// - port d bits 3..0 input enable overridden by irq enable, forced one
// - port d bits 7..4 feed timer0, timer1, serial1 clock, timer1 capture
// - serial1 clock output enable forces bit 5 output driven by that clock
// - clock-out fuse drives divided clock on port e bit 7 overriding port
// - divided clock also appears on port e bit 7 during reset
// - port e bits 5..3 carry timer3 compare and pwm waveforms
// - port e bit 2 direction selects serial0 clock output or input
// - serial0 clock on port e bit 2 only in synchronous mode
// - port e bit 7 feeds timer3 capture, bit 6 timer3 count
// - port e bits 7..4 external irq, enable overrides input enable
// - port d bit 0 feeds external interrupt 0
// - serial1 transmitter forces port d bit 3 output with transmit data
// - serial1 receiver forces port d bit 2 input, port bit keeps pull-up
`timescale 1ns/1ps
module port_d_e_alt_function_override
   import pin_override_pkg::*;
(
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // general-purpose port registers
   input  wire logic [PORT_W-1:0] portd_out,
   input  wire logic [PORT_W-1:0] portd_dir,
   input  wire logic [PORT_W-1:0] porte_out,
   input  wire logic [PORT_W-1:0] porte_dir,
   input  wire logic              pullup_global_disable,
   // pad inputs
   input  wire logic [PORT_W-1:0] portd_pad_in,
   input  wire logic [PORT_W-1:0] porte_pad_in,
   // two-wire interface
   input  wire logic              two_wire_enable,
   input  wire logic              two_wire_scl_drive_low,
   input  wire logic              two_wire_sda_drive_low,
   output logic                   two_wire_scl_in,
   output logic                   two_wire_sda_in,
   // serial ports
   input  wire logic              serial1_tx_enable,
   input  wire logic              serial1_rx_enable,
   input  wire logic              serial1_tx_line,
   input  wire logic              serial1_clk_out_enable,
   input  wire logic              serial1_clk_out,
   input  wire logic              serial0_sync_mode,
   input  wire logic              serial0_clk_out,
   output logic                   serial1_rx_line,
   output logic                   serial1_ext_clock,
   output logic                   serial0_ext_clock,
   // timers
   input  wire logic              timer3_compare_a_en,
   input  wire logic              timer3_compare_b_en,
   input  wire logic              timer3_compare_c_en,
   input  wire logic              timer3_compare_a_out,
   input  wire logic              timer3_compare_b_out,
   input  wire logic              timer3_compare_c_out,
   output logic                   timer0_count_in,
   output logic                   timer1_count_in,
   output logic                   timer1_capture_in,
   output logic                   timer3_count_in,
   output logic                   timer3_capture_in,
   // external interrupts: bits 3:0 and 7:4
   input  wire logic [PORT_W-1:0] ext_irq_enable,
   output logic [PORT_W-1:0]      ext_irq_in,
   // divided clock
   input  wire logic              clock_out_fuse,
   input  wire logic              divided_clock,
   // resolved pad controls
   output logic [PORT_W-1:0]      portd_pullup,
   output logic [PORT_W-1:0]      portd_oe,
   output logic [PORT_W-1:0]      portd_pad_out,
   output logic [PORT_W-1:0]      portd_in_enable,
   output logic                   portd_slew_limit,
   output logic [PORT_W-1:0]      porte_pullup,
   output logic [PORT_W-1:0]      porte_oe,
   output logic [PORT_W-1:0]      porte_pad_out,
   output logic [PORT_W-1:0]      porte_in_enable
);
   // override signal sets, per pin
   logic [PORT_W-1:0] d_pullup_override_en, d_pullup_override_val, d_direction_override_en, d_direction_override_val, d_pin_value_override_en, d_pin_value_override_val, d_input_enable_override_en;
   logic [PORT_W-1:0] e_pullup_override_en, e_pullup_override_val, e_direction_override_en, e_direction_override_val, e_pin_value_override_en, e_pin_value_override_val, e_input_enable_override_en;
   logic [PORT_W-1:0] next_portd_pullup, next_portd_oe, next_portd_pad_out;
   logic [PORT_W-1:0] next_porte_pullup, next_porte_oe, next_porte_pad_out;
   logic [PORT_W-1:0] next_portd_in_enable, next_porte_in_enable;
   logic              scl_filt, sda_filt;
   logic              next_divided_clock_pin;

   // pick override value while enabled, else port register value
   function automatic logic pick(input logic en, input logic ov, input logic normal);
      pick = en ? ov : normal;
   endfunction

   // spike filters on the two-wire inputs
   spike_filter u_scl_filter (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .raw_in   (portd_pad_in[PD_SCL]),
      .filt_out (scl_filt)
   );
   spike_filter u_sda_filter (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .raw_in   (portd_pad_in[PD_SDA]),
      .filt_out (sda_filt)
   );

   // port d override table
   always_comb begin
      d_pullup_override_en  = PORT_RESET;
      d_pullup_override_val  = PORT_RESET;
      d_direction_override_en  = PORT_RESET;
      d_direction_override_val  = PORT_RESET;
      d_pin_value_override_en  = PORT_RESET;
      d_pin_value_override_val  = PORT_RESET;
      d_input_enable_override_en = PORT_RESET;
      // two-wire clock and data, open-drain: drive low via direction only
      d_pullup_override_en[PD_SCL] = two_wire_enable;
      d_direction_override_en[PD_SCL] = two_wire_enable;
      d_pin_value_override_en[PD_SCL] = two_wire_enable;
      d_direction_override_val[PD_SCL] = two_wire_scl_drive_low;
      d_pullup_override_en[PD_SDA] = two_wire_enable;
      d_direction_override_en[PD_SDA] = two_wire_enable;
      d_pin_value_override_en[PD_SDA] = two_wire_enable;
      d_direction_override_val[PD_SDA] = two_wire_sda_drive_low;
      // serial1 receiver forces input, port bit keeps pull-up
      d_pullup_override_en[PD_RX1] = serial1_rx_enable;
      d_direction_override_en[PD_RX1] = serial1_rx_enable;
      // pull-up override for bits 2..0 (pullup term is active-high enable)
      for (int i = 0; i <= PD_RX1; i++) begin
         d_pullup_override_val[i] = portd_out[i] & ~pullup_global_disable;
      end
      // serial1 transmitter
      d_pullup_override_en[PD_TX1] = serial1_tx_enable;
      d_direction_override_en[PD_TX1] = serial1_tx_enable;
      d_direction_override_val[PD_TX1] = 1'b1;
      d_pin_value_override_en[PD_TX1] = serial1_tx_enable;
      d_pin_value_override_val[PD_TX1] = serial1_tx_line;
      // serial1 clock output
      d_direction_override_en[PD_SERIAL1_EXT_CLOCK] = serial1_clk_out_enable;
      d_direction_override_val[PD_SERIAL1_EXT_CLOCK] = 1'b1;
      d_pin_value_override_en[PD_SERIAL1_EXT_CLOCK] = serial1_clk_out_enable;
      d_pin_value_override_val[PD_SERIAL1_EXT_CLOCK] = serial1_clk_out;
      // external interrupt 3..0 input enable
      d_input_enable_override_en[3:0] = ext_irq_enable[3:0];
   end

   // port e override table
   always_comb begin
      e_pullup_override_en  = PORT_RESET;
      e_pullup_override_val  = PORT_RESET;
      e_direction_override_en  = PORT_RESET;
      e_direction_override_val  = PORT_RESET;
      e_pin_value_override_en  = PORT_RESET;
      e_pin_value_override_val  = PORT_RESET;
      e_input_enable_override_en = PORT_RESET;
      // compare/pwm outputs; direction left to software
      e_pin_value_override_en[PE_TIMER3_COMPARE_A_OUT] = timer3_compare_a_en;
      e_pin_value_override_val[PE_TIMER3_COMPARE_A_OUT] = timer3_compare_a_out;
      e_pin_value_override_en[PE_TIMER3_COMPARE_B_OUT] = timer3_compare_b_en;
      e_pin_value_override_val[PE_TIMER3_COMPARE_B_OUT] = timer3_compare_b_out;
      e_pin_value_override_en[PE_TIMER3_COMPARE_C_OUT] = timer3_compare_c_en;
      e_pin_value_override_val[PE_TIMER3_COMPARE_C_OUT] = timer3_compare_c_out;
      // serial0 clock output when direction set and synchronous
      e_direction_override_en[PE_SERIAL0_EXT_CLOCK] = serial0_sync_mode & porte_dir[PE_SERIAL0_EXT_CLOCK];
      e_direction_override_val[PE_SERIAL0_EXT_CLOCK] = 1'b1;
      e_pin_value_override_en[PE_SERIAL0_EXT_CLOCK] = serial0_sync_mode & porte_dir[PE_SERIAL0_EXT_CLOCK];
      e_pin_value_override_val[PE_SERIAL0_EXT_CLOCK] = serial0_clk_out;
      // divided clock on bit 7, also during reset
      e_direction_override_en[PE_DIVIDED_CLOCK_PIN] = clock_out_fuse | ~rst_n;
      e_direction_override_val[PE_DIVIDED_CLOCK_PIN] = 1'b1;
      e_pin_value_override_en[PE_DIVIDED_CLOCK_PIN] = clock_out_fuse | ~rst_n;
      e_pin_value_override_val[PE_DIVIDED_CLOCK_PIN] = divided_clock;
      // external interrupts 7..4
      e_input_enable_override_en[7:4] = ext_irq_enable[7:4];
   end

   // resolve each pin attribute
   always_comb begin
      for (int i = 0; i < PORT_W; i++) begin
         next_portd_pullup[i]    = pick(d_pullup_override_en[i], d_pullup_override_val[i],
                                        portd_out[i] & ~portd_dir[i] & ~pullup_global_disable);
         next_portd_oe[i]        = pick(d_direction_override_en[i], d_direction_override_val[i], portd_dir[i]);
         next_portd_pad_out[i]   = pick(d_pin_value_override_en[i], d_pin_value_override_val[i], portd_out[i]);
         next_portd_in_enable[i] = pick(d_input_enable_override_en[i], 1'b1, 1'b1);
         next_porte_pullup[i]    = pick(e_pullup_override_en[i], e_pullup_override_val[i],
                                        porte_out[i] & ~porte_dir[i] & ~pullup_global_disable);
         next_porte_oe[i]        = pick(e_direction_override_en[i], e_direction_override_val[i], porte_dir[i]);
         next_porte_pad_out[i]   = pick(e_pin_value_override_en[i], e_pin_value_override_val[i], porte_out[i]);
         next_porte_in_enable[i] = pick(e_input_enable_override_en[i], 1'b1, 1'b1);
      end
   end

   // bit 7 clock path bypasses registers so reset shows the clock
   assign next_divided_clock_pin = e_pin_value_override_en[PE_DIVIDED_CLOCK_PIN];

   // registered pad controls; bit 7 of port e stays combinational for the clock
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         portd_pullup    <= PORT_RESET;
         portd_oe        <= PORT_RESET;
         portd_pad_out   <= PORT_RESET;
         portd_in_enable <= 8'hff;
         porte_pullup    <= PORT_RESET;
         porte_in_enable <= 8'hff;
      end else begin
         portd_pullup    <= next_portd_pullup;
         portd_oe        <= next_portd_oe;
         portd_pad_out   <= next_portd_pad_out;
         portd_in_enable <= next_portd_in_enable;
         porte_pullup    <= next_porte_pullup;
         porte_in_enable <= next_porte_in_enable;
      end
   end

   // port e drive: bit 7 carries divided clock directly, others registered
   logic [PORT_W-2:0] porte_oe_q, porte_out_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         porte_oe_q  <= 7'h00;
         porte_out_q <= 7'h00;
      end else begin
         porte_oe_q  <= next_porte_oe[PORT_W-2:0];
         porte_out_q <= next_porte_pad_out[PORT_W-2:0];
      end
   end
   assign porte_oe      = {next_divided_clock_pin | porte_dir[PE_DIVIDED_CLOCK_PIN] & rst_n, porte_oe_q};
   assign porte_pad_out = {next_porte_pad_out[PE_DIVIDED_CLOCK_PIN] & rst_n | next_divided_clock_pin & divided_clock,
                           porte_out_q};

   // slew control while two-wire active
   assign portd_slew_limit = two_wire_enable;

   // peripheral inputs
   assign two_wire_scl_in   = two_wire_enable ? scl_filt : 1'b1;
   assign two_wire_sda_in   = two_wire_enable ? sda_filt : 1'b1;
   assign ext_irq_in        = {porte_pad_in[7:4], portd_pad_in[3:0]};
   assign serial1_rx_line   = portd_pad_in[PD_RX1];
   assign timer0_count_in   = portd_pad_in[PD_T0];
   assign timer1_count_in   = portd_pad_in[PD_T1];
   assign serial1_ext_clock = portd_pad_in[PD_SERIAL1_EXT_CLOCK];
   assign timer1_capture_in = portd_pad_in[PD_CAP1];
   assign serial0_ext_clock = serial0_sync_mode & porte_pad_in[PE_SERIAL0_EXT_CLOCK];
   assign timer3_count_in   = porte_pad_in[PE_T3];
   assign timer3_capture_in = porte_pad_in[PE_DIVIDED_CLOCK_PIN];
endmodule

// file: pad_model.sv
// pad model: resolves each pin from block drive, external driver and pull-up
`timescale 1ns/1ps
module pad_model
   import pin_override_pkg::*;
(
   // clock
   input  wire logic              clk_sys,
   // block side
   input  wire logic [PORT_W-1:0] oe,
   input  wire logic [PORT_W-1:0] pad_out,
   input  wire logic [PORT_W-1:0] pull_on,
   // external side
   input  wire logic [PORT_W-1:0] ext_en,
   input  wire logic [PORT_W-1:0] ext_val,
   output logic [PORT_W-1:0]      pad_in
);
   logic [PORT_W-1:0] float_pat = 8'h55;
   // undriven pins without pull-up wander every cycle
   always @(posedge clk_sys) float_pat <= ~float_pat;
   // block drive wins; an open-drain low shows up as oe with a zero value
   assign pad_in = (oe & pad_out) | (~oe & ext_en & ext_val)
                 | (~oe & ~ext_en & (pull_on | float_pat));
endmodule

// file: pin_override_monitor.sv
// concurrent checks on the port d / port e override block
`timescale 1ns/1ps
module pin_override_monitor
   import pin_override_pkg::*;
(
   // scalar ports
   input wire logic clk_sys, rst_n, pullup_global_disable, two_wire_enable, clock_out_fuse,
   input wire logic two_wire_scl_drive_low, two_wire_sda_drive_low, serial1_tx_enable,
   input wire logic serial1_rx_enable, serial1_tx_line, divided_clock, portd_slew_limit,
   input wire logic timer0_count_in, timer1_count_in, timer1_capture_in, serial1_ext_clock,
   input wire logic timer3_count_in, timer3_capture_in,
   // vector ports
   input wire logic [PORT_W-1:0] portd_out, portd_dir, portd_pad_in, porte_pad_in, ext_irq_in,
   input wire logic [PORT_W-1:0] portd_pullup, portd_oe, portd_pad_out, portd_in_enable,
   input wire logic [PORT_W-1:0] porte_oe, porte_pad_out, porte_in_enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // pin forcing by peripherals, one cycle after the request; fuse clock on port e bit 7 in the same cycle
   tx_force_a: assert property (serial1_tx_enable |=> portd_oe[3] &&
      portd_pad_out[3] == $past(serial1_tx_line)) else $error("tx pin not forced");
   rx_force_a: assert property (serial1_rx_enable |=> !portd_oe[2] &&
      portd_pullup[2] == $past(portd_out[2] & ~pullup_global_disable)) else $error("rx pin");
   two_wire_drive_a: assert property (two_wire_enable |=> portd_pad_out[1:0] == 2'h0 &&
      portd_oe[1:0] == $past({two_wire_sda_drive_low, two_wire_scl_drive_low}))
      else $error("two-wire drive wrong");
   slew_ctrl_a: assert property (portd_slew_limit == two_wire_enable)
      else $error("slew control wrong");
   clock_out_a: assert property (clock_out_fuse |-> porte_oe[7] &&
      porte_pad_out[7] == divided_clock) else $error("divided clock missing");
   route_in_a: assert property ({timer0_count_in, timer1_count_in, serial1_ext_clock,
      timer1_capture_in, timer3_capture_in, timer3_count_in} ==
      {portd_pad_in[7:4], porte_pad_in[7:6]}) else $error("peripheral input route");
   irq_map_a: assert property (ext_irq_in == {porte_pad_in[7:4], portd_pad_in[3:0]})
      else $error("irq input route");
   in_enable_a: assert property ($past(rst_n) |-> portd_in_enable == 8'hff &&
      porte_in_enable[7:4] == 4'hf) else $error("input enable low");
   plain_port_a: assert property (1'b1 |=> {portd_oe[7:6], portd_oe[4]} ==
      $past({portd_dir[7:6], portd_dir[4]}) && portd_pullup[7] ==
      $past(portd_out[7] & ~portd_dir[7] & ~pullup_global_disable)) else $error("plain port");
   // main scenarios reached
   cover property (two_wire_enable && portd_oe[0]);
   cover property (serial1_tx_enable ##1 portd_oe[3]);
   cover property (clock_out_fuse && porte_oe[7]);
endmodule
bind port_d_e_alt_function_override pin_override_monitor pin_override_monitor_inst (
   .clk_sys(clk_sys), .rst_n(rst_n), .pullup_global_disable(pullup_global_disable),
   .two_wire_enable(two_wire_enable), .clock_out_fuse(clock_out_fuse),
   .two_wire_scl_drive_low(two_wire_scl_drive_low),
   .two_wire_sda_drive_low(two_wire_sda_drive_low), .serial1_tx_enable(serial1_tx_enable),
   .serial1_rx_enable(serial1_rx_enable), .serial1_tx_line(serial1_tx_line),
   .divided_clock(divided_clock), .portd_slew_limit(portd_slew_limit),
   .timer0_count_in(timer0_count_in), .timer1_count_in(timer1_count_in),
   .timer1_capture_in(timer1_capture_in), .serial1_ext_clock(serial1_ext_clock),
   .timer3_count_in(timer3_count_in), .timer3_capture_in(timer3_capture_in),
   .portd_out(portd_out), .portd_dir(portd_dir), .portd_pad_in(portd_pad_in),
   .porte_pad_in(porte_pad_in), .ext_irq_in(ext_irq_in), .portd_pullup(portd_pullup),
   .portd_oe(portd_oe), .portd_pad_out(portd_pad_out), .portd_in_enable(portd_in_enable),
   .porte_oe(porte_oe), .porte_pad_out(porte_pad_out), .porte_in_enable(porte_in_enable));

// file: tb_port_d_e_alt_function_override.sv
// self-checking bench for the port d / port e override block
`timescale 1ns/1ps
module tb_port_d_e_alt_function_override
   import pin_override_pkg::*;
();
   // stimulus and observed signals
   logic clk_sys, rst_n, pgd, tw_en, scl_dl, sda_dl, tx_en, rx_en, tx_ln, x1_en, x1_o, sync0;
   logic x0_o, oa_en, ob_en, oc_en, oa, ob, oc, fuse, dclk, slew, scl_i, sda_i, rx_ln, x1_i;
   logic x0_i, t0, t1, cap1, t3, cap3;
   logic [PORT_W-1:0] pdo, pdd, peo, ped, irq_en, d_xen, d_x, e_x, d_pad, e_pad, irq_i;
   logic [PORT_W-1:0] d_pu, d_oe, d_po, d_ie, e_pu, e_oe, e_po, e_ie;
   int fails = 0;
   int checked = 0;
   port_d_e_alt_function_override port_d_e_alt_function_override_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .portd_out(pdo), .portd_dir(pdd), .porte_out(peo),
      .porte_dir(ped), .pullup_global_disable(pgd), .portd_pad_in(d_pad), .porte_pad_in(e_pad),
      .two_wire_enable(tw_en), .two_wire_scl_drive_low(scl_dl), .two_wire_sda_drive_low(sda_dl),
      .two_wire_scl_in(scl_i), .two_wire_sda_in(sda_i), .serial1_tx_enable(tx_en),
      .serial1_rx_enable(rx_en), .serial1_tx_line(tx_ln), .serial1_clk_out_enable(x1_en),
      .serial1_clk_out(x1_o), .serial0_sync_mode(sync0), .serial0_clk_out(x0_o),
      .serial1_rx_line(rx_ln), .serial1_ext_clock(x1_i), .serial0_ext_clock(x0_i),
      .timer3_compare_a_en(oa_en), .timer3_compare_b_en(ob_en), .timer3_compare_c_en(oc_en),
      .timer3_compare_a_out(oa), .timer3_compare_b_out(ob), .timer3_compare_c_out(oc),
      .timer0_count_in(t0), .timer1_count_in(t1), .timer1_capture_in(cap1),
      .timer3_count_in(t3), .timer3_capture_in(cap3), .ext_irq_enable(irq_en),
      .ext_irq_in(irq_i), .clock_out_fuse(fuse), .divided_clock(dclk), .portd_pullup(d_pu),
      .portd_oe(d_oe), .portd_pad_out(d_po), .portd_in_enable(d_ie), .portd_slew_limit(slew),
      .porte_pullup(e_pu), .porte_oe(e_oe), .porte_pad_out(e_po), .porte_in_enable(e_ie));
   pad_model pad_model_inst (.clk_sys(clk_sys), .oe(d_oe), .pad_out(d_po), .pull_on(d_pu),
      .ext_en(d_xen), .ext_val(d_x), .pad_in(d_pad));
   pad_model pad_model_e_inst (.clk_sys(clk_sys), .oe(e_oe), .pad_out(e_po), .pull_on(e_pu),
      .ext_en(8'hff), .ext_val(e_x), .pad_in(e_pad));
   // system clock and a divided clock toggling every cycle
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) dclk <= ~dclk;
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_reset;
      tick(5);
      chk("reset clock oe", e_oe[7], 1'b1);
      chk("reset clock out", e_po[7], dclk);
      @(posedge clk_sys);
      rst_n <= 1'b1;
   endtask
   task automatic t_normal;
      @(posedge clk_sys);
      {pdd, pdo, ped, peo} <= {8'hc3, 8'ha5, 8'h38, 8'hc8};
      tick(1);
      chk("normal oe", d_oe, 8'hc3);
      chk("normal out", d_po, 8'ha5);
      chk("normal pull-up", d_pu, 8'h24);
      chk("port e oe", {1'b0, e_oe[6:0]}, 8'h38);
      chk("port e pull-up", e_pu, 8'hc0);
      @(posedge clk_sys);
      pgd <= 1'b1;
      tick(1);
      chk("pull-up disabled", d_pu, 8'h00);
      chk("port e pull-up disabled", e_pu, 8'h00);
   endtask
   task automatic t_serial1;
      @(posedge clk_sys);
      {tx_en, tx_ln, rx_en, pgd, pdd, pdo} <= {4'b1010, 8'h04, 8'h04};
      tick(1);
      chk("tx rx oe", d_oe[3:2], 2'b10);
      chk("tx data low", d_po[3], 1'b0);
      chk("rx pull-up", d_pu[2], 1'b1);
      @(posedge clk_sys);
      {tx_ln, pgd} <= 2'b11;
      tick(1);
      chk("tx data high", d_po[3], 1'b1);
      chk("rx pull-up off", d_pu[2], 1'b0);
      @(posedge clk_sys);
      {tx_en, rx_en, pgd} <= 3'b000;
   endtask
   task automatic t_two_wire;
      @(posedge clk_sys);
      {tw_en, scl_dl, sda_dl, pdo, pdd, d_xen, d_x} <= {3'b110, 8'h03, 8'h00, 8'h03, 8'h03};
      tick(1);
      chk("two-wire oe", d_oe[1:0], 2'b01);
      chk("two-wire out", d_po[1:0], 2'b00);
      chk("two-wire pull-up", d_pu[1:0], 2'b11);
      chk("slew on", slew, 1'b1);
      tick(SPIKE_CYCLES + 3);
      chk("clock line low", scl_i, 1'b0);
      @(posedge clk_sys);
      d_x[1] <= 1'b0;
      repeat (SPIKE_CYCLES - 2) @(posedge clk_sys);
      d_x[1] <= 1'b1;
      repeat (SPIKE_CYCLES + 2) begin
         tick(1);
         chk("spike dropped", sda_i, 1'b1);
      end
      @(posedge clk_sys);
      scl_dl <= 1'b0;
      tick(SPIKE_CYCLES + 3);
      chk("clock line high", scl_i, 1'b1);
      @(posedge clk_sys);
      tw_en <= 1'b0;
      tick(1);
      chk("slew off", slew, 1'b0);
   endtask
   task automatic t_clock_out;
      @(posedge clk_sys);
      {fuse, ped, peo} <= {1'b1, 16'h0000};
      repeat (2) begin
         tick(1);
         chk("fuse clock oe", e_oe[7], 1'b1);
         chk("fuse clock out", e_po[7], dclk);
      end
      @(posedge clk_sys);
      fuse <= 1'b0;
      tick(1);
      chk("fuse off oe", e_oe[7], 1'b0);
   endtask
   task automatic t_periph;
      @(posedge clk_sys);
      {x1_en, x1_o, oa_en, ob_en, oc_en, oa, ob, oc, sync0, x0_o} <= 10'h3f7;
      {ped, peo} <= {8'h3c, 8'h00};
      tick(1);
      chk("serial1 clock", {d_oe[5], d_po[5]}, 2'b11);
      chk("compare outs", e_po[5:3], 3'b101);
      chk("serial0 clock", e_po[2], 1'b1);
      chk("serial0 clock in", x0_i, 1'b1);
      @(posedge clk_sys);
      {x1_en, sync0} <= 2'b00;
      tick(1);
      chk("serial0 async", e_po[2], 1'b0);
      chk("serial0 clock in off", x0_i, 1'b0);
      chk("serial1 clock off", d_oe[5], 1'b0);
   endtask
   task automatic t_routes;
      logic [7:0] p;
      for (int i = 0; i < 2; i++) begin
         p = (i == 0) ? 8'h5a : 8'ha5;
         @(posedge clk_sys);
         {ped, d_xen, d_x, e_x, irq_en} <= {8'h00, 8'hff, p, ~p, p};
         tick(1);
         chk("port d routes", {t0, t1, x1_i, cap1}, p[7:4]);
         chk("port e routes", {cap3, t3}, {~p[7], ~p[6]});
         chk("irq routes", irq_i, {~p[7:4], p[3:0]});
         chk("rx line", rx_ln, p[2]);
         chk("in enable", d_ie, 8'hff);
         chk("port e in enable", e_ie, 8'hff);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      {rst_n, pgd, tw_en, scl_dl, sda_dl, tx_en, rx_en, tx_ln, x1_en, x1_o, sync0, x0_o} = '0;
      {oa_en, ob_en, oc_en, oa, ob, oc, fuse, dclk} = '0;
      {pdo, pdd, peo, ped, irq_en, d_xen, d_x, e_x} = '0;
      t_reset();
      t_normal();
      t_serial1();
      t_two_wire();
      t_clock_out();
      t_periph();
      t_routes();
      end_sim();
   end
   // watchdog well beyond the roughly 60 cycles the tests need
   initial begin
      #50000;
      fails++;
      end_sim();
   end
endmodule
